// >>> rbw_pkg.sv
// relay-board watchdog: shared constants, register map and carrier types
// assumes a 100 MHz ref_clk and a 32-bit classic wishbone register bus
package rbw_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ = 100_000_000; // ref_clk rate
  localparam int unsigned HB_PERIOD_S = 3; // host heartbeat cycle, seconds
  localparam int unsigned WDOG_TIMEOUT_S = 30; // stuck indicator limit, seconds
  // stuck time in cycles; 3e9 fits in 32 unsigned bits, product formed in 64 bits before narrowing
  localparam longint unsigned WDOG_CYC = 64'(WDOG_TIMEOUT_S) * 64'(CLK_HZ);

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00; // relay command, rw
  localparam logic [7:0] STATUS_OFS = 8'h04; // live outputs and trip, ro
  localparam logic [7:0] TIMER_OFS = 8'h08; // cycles since last heartbeat edge, ro
  localparam logic [7:0] IRQ_STAT_OFS = 8'h0c; // sticky events, ro
  localparam logic [7:0] IRQ_CLR_OFS = 8'h10; // write one to clear, wo
  localparam logic [7:0] IRQ_EN_OFS = 8'h14; // event enables, rw

  ////////////////////////////////////////////////////////////////////////////
  // field positions and reset values
  localparam int unsigned CTRL_W = 7; // command bits in the ctrl word
  localparam logic [6:0] CTRL_RST = 7'h40; // motor on, everything else off
  localparam int unsigned STATUS_TRIP_BIT = 8; // status: shutdown active
  localparam int unsigned EV_W = 3; // interrupt event count
  localparam int unsigned EV_TRIP = 0; // watchdog tripped
  localparam int unsigned EV_RECOVER = 1; // heartbeat resumed after a trip
  localparam int unsigned EV_BEAT = 2; // heartbeat changed state
  localparam logic [2:0] EV_RST = 3'h0; // status and enable reset value

  ////////////////////////////////////////////////////////////////////////////
  // carrier types
  // command word as written by software, lsb = heartbeat
  typedef struct packed {
    logic motor; // wheel motor run
    logic shutoff; // shutoff valve open to cal gas
    logic span; // zero/span valve on span
    logic cal; // sample/cal valve on cal
    logic bench; // bench heater drive
    logic wheel; // wheel heater drive
    logic beat; // heartbeat level
  } rbw_ctrl_t;

  // switch and relay drives
  typedef struct packed {
    logic motor;
    logic ir_source;
    logic shutoff;
    logic span;
    logic cal;
    logic bench;
    logic wheel;
  } rbw_relay_t;

  // board status indicators, lit = 1
  typedef struct packed {
    logic ir_source;
    logic shutoff;
    logic span;
    logic cal;
    logic bench;
    logic wheel;
    logic heartbeat_indicator;
  } rbw_led_t;

  // watchdog states
  typedef enum logic {WD_RUN, WD_TRIP} rbw_wd_state_t;

endpackage

// >>> rbw_relay_watchdog.sv
// relay board core: command register, heartbeat watchdog, relay drives, leds
// assumes a wishbone classic master on ref_clk and synchronous srst
// Operation
// (RULE1) host toggles heartbeat every three seconds
// (RULE2) heartbeat indicator follows supervised bus writes
// (RULE3) thirty seconds stuck forces valves, source, heaters off
// (RULE4) timeout leaves wheel motor running
// (RULE5) ir source on unless shutdown forces off
// (RULE6) heater indicators lit while heater driven
// (RULE7) cal valve indicator lit on calibration gas
// (RULE8) span valve indicator lit on span gas
// (RULE9) shutoff indicator lit while cal gas flows
// (RULE10) bus commands decoded into relay outputs
// (RULE11) heartbeat edge restarts timer, clears shutdown
`timescale 1ns/1ps
`default_nettype none

module rbw_relay_watchdog #(
  parameter logic [31:0] TIMEOUT_CYC = 32'(rbw_pkg::WDOG_CYC) // stuck limit in cycles
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  // wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // relay drives and indicators
  output var rbw_pkg::rbw_relay_t relay_o,
  output var rbw_pkg::rbw_led_t led_o,
  // interrupt
  output logic irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic ack_q, ack_d; // bus answer
  logic [31:0] rdat_q, rdat_d; // read data
  rbw_pkg::rbw_ctrl_t ctrl_q, ctrl_d; // software command word
  rbw_pkg::rbw_wd_state_t wd_q, wd_d; // watchdog state
  logic [31:0] cnt_q, cnt_d; // cycles since last heartbeat change
  rbw_pkg::rbw_relay_t out_q, out_d; // registered drives
  rbw_pkg::rbw_led_t led_q, led_d; // registered indicators
  logic [rbw_pkg::EV_W-1:0] ist_q, ist_d; // sticky events
  logic [rbw_pkg::EV_W-1:0] ien_q, ien_d; // event enables
  logic irq_q, irq_d; // interrupt level

  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  logic acc; // request taken this cycle
  logic wr; // write taken this cycle
  logic hit_ctrl, hit_stat, hit_tmr, hit_ist, hit_iclr, hit_ien;
  rbw_pkg::rbw_ctrl_t wctrl; // ctrl word as it would be after this write
  logic beat_chg; // heartbeat level changes this cycle
  logic [rbw_pkg::EV_W-1:0] ev; // events raised this cycle

  // one answer per request; ack drops the cycle after it was given
  assign acc = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = acc && wb_we_i;

  // register select, if/else-if chain
  always_comb begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    hit_tmr = 1'b0;
    hit_ist = 1'b0;
    hit_iclr = 1'b0;
    hit_ien = 1'b0;
    if (wb_adr_i == rbw_pkg::CTRL_OFS) begin
      hit_ctrl = 1'b1;
    end else if (wb_adr_i == rbw_pkg::STATUS_OFS) begin
      hit_stat = 1'b1;
    end else if (wb_adr_i == rbw_pkg::TIMER_OFS) begin
      hit_tmr = 1'b1;
    end else if (wb_adr_i == rbw_pkg::IRQ_STAT_OFS) begin
      hit_ist = 1'b1;
    end else if (wb_adr_i == rbw_pkg::IRQ_CLR_OFS) begin
      hit_iclr = 1'b1;
    end else if (wb_adr_i == rbw_pkg::IRQ_EN_OFS) begin
      hit_ien = 1'b1;
    end
  end

  // forced drive pattern: shutdown kills valves, source, heaters only
  function automatic rbw_pkg::rbw_relay_t drive(input rbw_pkg::rbw_ctrl_t c,
                                               input logic tripped);
    rbw_pkg::rbw_relay_t r;
    r.motor = c.motor; // RULE4
    r.ir_source = !tripped; // RULE5
    r.shutoff = c.shutoff && !tripped; // RULE3
    r.span = c.span && !tripped;
    r.cal = c.cal && !tripped;
    r.bench = c.bench && !tripped;
    r.wheel = c.wheel && !tripped;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus answer and command register
  always_comb begin
    ack_d = acc;
    rdat_d = rdat_q;
    ctrl_d = ctrl_q;
    wctrl = ctrl_q;
    // only the low byte lane carries command bits
    if (wr && hit_ctrl && wb_sel_i[0]) begin
      wctrl = rbw_pkg::rbw_ctrl_t'(wb_dat_i[rbw_pkg::CTRL_W-1:0]); // RULE10
    end
    ctrl_d = wctrl;
    // reads: unmapped and write-only offsets answer zero
    if (acc && !wb_we_i) begin
      rdat_d = 32'h0000_0000;
      if (hit_ctrl) begin
        rdat_d[rbw_pkg::CTRL_W-1:0] = ctrl_q;
      end else if (hit_stat) begin
        rdat_d[rbw_pkg::CTRL_W-1:0] = out_q;
        rdat_d[rbw_pkg::STATUS_TRIP_BIT] = (wd_q == rbw_pkg::WD_TRIP);
      end else if (hit_tmr) begin
        rdat_d = cnt_q;
      end else if (hit_ist) begin
        rdat_d[rbw_pkg::EV_W-1:0] = ist_q;
      end else if (hit_ien) begin
        rdat_d[rbw_pkg::EV_W-1:0] = ien_q;
      end
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      ctrl_q <= rbw_pkg::rbw_ctrl_t'(rbw_pkg::CTRL_RST);
    end else if (ce) begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      ctrl_q <= ctrl_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  ////////////////////////////////////////////////////////////////////////////
  // heartbeat watchdog
  // the host's bus writes are the supervised activity; only a level change
  // counts, so a host that writes the same level forever still trips
  assign beat_chg = (wctrl.beat != ctrl_q.beat); // RULE2

  always_comb begin
    wd_d = wd_q;
    cnt_d = cnt_q;
    ev = '0;
    if (beat_chg) begin
      cnt_d = 32'h0000_0000; // RULE11
      ev[rbw_pkg::EV_BEAT] = 1'b1;
      // toggling again ends the shutdown
      if (wd_q == rbw_pkg::WD_TRIP) begin
        ev[rbw_pkg::EV_RECOVER] = 1'b1;
      end
      wd_d = rbw_pkg::WD_RUN; // RULE11
    end else begin
      case (wd_q)
        rbw_pkg::WD_RUN: begin
          // trips on the cycle the indicator has been still for the limit
          if (cnt_q == TIMEOUT_CYC - 32'd1) begin
            wd_d = rbw_pkg::WD_TRIP; // RULE3
            ev[rbw_pkg::EV_TRIP] = 1'b1;
          end else begin
            cnt_d = cnt_q + 32'd1;
          end
        end
        rbw_pkg::WD_TRIP: begin
          // counter parks at TIMEOUT_CYC - 1, readable as proof of the stall
          cnt_d = cnt_q;
        end
        default: begin
          wd_d = rbw_pkg::WD_RUN;
        end
      endcase
    end
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wd_q <= rbw_pkg::WD_RUN;
      cnt_q <= 32'h0000_0000;
    end else if (ce) begin
      wd_q <= wd_d;
      cnt_q <= cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // drives and indicators, both from one registered pattern
  always_comb begin
    out_d = drive(ctrl_q, wd_q == rbw_pkg::WD_TRIP); // RULE3
    led_d.heartbeat_indicator = ctrl_q.beat; // RULE2
    led_d.wheel = out_d.wheel; // RULE6
    led_d.bench = out_d.bench; // RULE6
    led_d.cal = out_d.cal; // RULE7
    led_d.span = out_d.span; // RULE8
    led_d.shutoff = out_d.shutoff; // RULE9
    led_d.ir_source = out_d.ir_source;
  end

  // registers only; reset pattern keeps motor on and source lit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      out_q <= drive(rbw_pkg::rbw_ctrl_t'(rbw_pkg::CTRL_RST), 1'b0);
      led_q <= rbw_pkg::rbw_led_t'(7'h40);
    end else if (ce) begin
      out_q <= out_d;
      led_q <= led_d;
    end
  end

  assign relay_o = out_q;
  assign led_o = led_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: sticky status, write-one clear, enable, level output
  always_comb begin
    ist_d = ist_q;
    ien_d = ien_q;
    if (wr && hit_iclr && wb_sel_i[0]) begin
      ist_d = ist_q & ~wb_dat_i[rbw_pkg::EV_W-1:0];
    end
    // a new event beats a clear in the same cycle
    ist_d = ist_d | ev;
    if (wr && hit_ien && wb_sel_i[0]) begin
      ien_d = wb_dat_i[rbw_pkg::EV_W-1:0];
    end
    irq_d = |(ist_d & ien_d);
  end

  // registers only
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ist_q <= rbw_pkg::EV_RST;
      ien_q <= rbw_pkg::EV_RST;
      irq_q <= 1'b0;
    end else if (ce) begin
      ist_q <= ist_d;
      ien_q <= ien_d;
      irq_q <= irq_d;
    end
  end

  assign irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  chk_trip_time: assert property (@(posedge ref_clk) disable iff (srst) // RULE3
    $rose(wd_q == rbw_pkg::WD_TRIP) |-> $past(cnt_q) == TIMEOUT_CYC - 32'd1)
    else $error("trip without full stuck time");

  chk_force_off: assert property (@(posedge ref_clk) disable iff (srst) // RULE3
    ce && wd_q == rbw_pkg::WD_TRIP |=> relay_o.ir_source == 1'b0 && relay_o.cal == 1'b0
      && relay_o.span == 1'b0 && relay_o.shutoff == 1'b0 && relay_o.wheel == 1'b0
      && relay_o.bench == 1'b0)
    else $error("outputs not forced off in shutdown");

  chk_motor_kept: assert property (@(posedge ref_clk) disable iff (srst) // RULE4
    ce ##1 1'b1 |-> relay_o.motor == $past(ctrl_q.motor))
    else $error("motor drive does not follow command");

  chk_source_on: assert property (@(posedge ref_clk) disable iff (srst) // RULE5
    ce && wd_q == rbw_pkg::WD_RUN |=> relay_o.ir_source)
    else $error("ir source off in normal running");

  chk_heater_led: assert property (@(posedge ref_clk) disable iff (srst) // RULE6
    led_o.wheel == relay_o.wheel && led_o.bench == relay_o.bench)
    else $error("heater indicator disagrees with drive");

  chk_cal_led: assert property (@(posedge ref_clk) disable iff (srst) // RULE7
    led_o.cal == relay_o.cal)
    else $error("cal valve indicator wrong");

  chk_span_led: assert property (@(posedge ref_clk) disable iff (srst) // RULE8
    led_o.span == relay_o.span)
    else $error("span valve indicator wrong");

  chk_shutoff_led: assert property (@(posedge ref_clk) disable iff (srst) // RULE9
    led_o.shutoff == relay_o.shutoff)
    else $error("shutoff indicator wrong");

  chk_beat_follow: assert property (@(posedge ref_clk) disable iff (srst) // RULE2
    ce && wr && hit_ctrl && wb_sel_i[0] ##1 ce |=>
      led_o.heartbeat_indicator == $past(wb_dat_i[0], 2))
    else $error("heartbeat indicator does not follow write");

  chk_cmd_apply: assert property (@(posedge ref_clk) disable iff (srst) // RULE10
    ce && wr && hit_ctrl && wb_sel_i[0] |=> ctrl_q == $past(wb_dat_i[rbw_pkg::CTRL_W-1:0]))
    else $error("command write not applied");

  chk_beat_restart: assert property (@(posedge ref_clk) disable iff (srst) // RULE11
    ce && beat_chg |=> cnt_q == 32'h0000_0000 && wd_q == rbw_pkg::WD_RUN)
    else $error("heartbeat change did not restart watchdog");

  // shutdown must not lapse on its own; only a new heartbeat level ends it
  chk_trip_hold: assert property (@(posedge ref_clk) disable iff (srst) // RULE11
    wd_q == rbw_pkg::WD_TRIP && !(ce && beat_chg) |=> wd_q == rbw_pkg::WD_TRIP)
    else $error("shutdown ended without heartbeat change");

endmodule

`default_nettype wire

// >>> rbw_host_model.sv
// host model: runs one classic wishbone cycle per request from the bench
// assumes go is a one-cycle pulse given only while the model is idle
`timescale 1ns/1ps
`default_nettype none
module rbw_host_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // bench request and result
  input wire logic go,
  input wire logic we,
  input wire logic [7:0] adr,
  input wire logic [31:0] dat,
  output logic done,
  output logic [31:0] rdat,
  // wishbone master side
  output logic wb_cyc,
  output logic wb_we,
  output logic [7:0] wb_adr,
  output logic [31:0] wb_dat,
  input wire logic wb_ack,
  input wire logic [31:0] wb_rdat
);
  ////////////////////////////////////////////////////////////////////////////
  // request held until ack; the done cycle forces one idle cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wb_cyc <= 1'b0;
      done <= 1'b0;
    end else if (wb_cyc && wb_ack) begin
      // release; stale values inverted so nothing reads them as live
      wb_cyc <= 1'b0;
      wb_adr <= ~wb_adr;
      wb_dat <= ~wb_dat;
      rdat <= wb_rdat;
      done <= 1'b1;
    end else if (go && !wb_cyc && !done) begin
      wb_cyc <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat <= dat;
    end else begin
      done <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> relay_board_bus_watchdog_tb.sv
// bench for the relay board watchdog: bus commands, indicators, trip, recovery
// assumes timeout shortened to 50 cycles; ce high except in the freeze scenario
`timescale 1ns/1ps
`default_nettype none
module relay_board_bus_watchdog_tb;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1; // clock enable, dropped only to prove the freeze
  logic go = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic done, cyc, wwe, ack, irq;
  logic [7:0] wadr;
  logic [31:0] wdat, rdat, wrd;
  rbw_pkg::rbw_relay_t relay;
  rbw_pkg::rbw_led_t led;
  int error_cnt = 0;
  int check_count = 0;
  logic bt = 1'b0; // heartbeat level last written
  logic [6:0] c; // command last written
  ////////////////////////////////////////////////////////////////////////////
  rbw_relay_watchdog #(.TIMEOUT_CYC(32'h32)) rbw_relay_watchdog_i (.ref_clk(ref_clk),
    .srst(srst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(wwe), .wb_adr_i(wadr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wrd), .wb_ack_o(ack), .relay_o(relay),
    .led_o(led), .irq_o(irq));
  rbw_host_model rbw_host_model_i (.ref_clk(ref_clk), .srst(srst), .go(go), .we(we),
    .adr(adr), .dat(dat), .done(done), .rdat(rdat), .wb_cyc(cyc), .wb_we(wwe),
    .wb_adr(wadr), .wb_dat(wdat), .wb_ack(ack), .wb_rdat(wrd));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one bus cycle through the host model; a lost ack ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge ref_clk);
    go <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge ref_clk);
    go <= 1'b0;
    for (i = 0; i < 20 && done !== 1'b1; i++) @(posedge ref_clk);
    if (done !== 1'b1) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask
  // toggles the heartbeat with each new command
  task automatic cmd(input logic [6:0] v);
    bt = ~bt;
    c = v | {6'h0, bt};
    bus(1'b1, rbw_pkg::CTRL_OFS, {25'h0, c});
    ticks(2);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset();
    check({25'h0, relay}, 32'h60);
    check({25'h0, led}, 32'h40);
    rd(rbw_pkg::CTRL_OFS, 32'h40);
    rd(rbw_pkg::IRQ_EN_OFS, 32'h0);
  endtask
  // each valve and heater field alone, with motor on, drives its relay and indicator; beat events stay masked
  task automatic t_cmds();
    for (int b = 1; b < 6; b++) begin
      cmd(7'h40 | 7'(1 << b));
      check({25'h0, relay}, {25'h0, c[6], 1'b1, c[5:1]});
      check({25'h0, led}, {25'h0, 1'b1, c[5:1], bt});
      rd(rbw_pkg::STATUS_OFS, {25'h0, c[6], 1'b1, c[5:1]});
    end
    rd(rbw_pkg::IRQ_STAT_OFS, 32'h4);
    check({31'h0, irq}, 32'h0);
  endtask
  task automatic t_unmapped();
    rd(8'h20, 32'h0);
    bus(1'b1, 8'h20, 32'hffff_ffff);
    rd(rbw_pkg::CTRL_OFS, {25'h0, c});
    rd(rbw_pkg::IRQ_CLR_OFS, 32'h0);
  endtask
  // same-level beat write must not restart the stuck timer
  task automatic t_trip();
    int i;
    bus(1'b1, rbw_pkg::IRQ_EN_OFS, 32'h1);
    bus(1'b1, rbw_pkg::IRQ_CLR_OFS, 32'h7);
    cmd(7'h7e);
    check({25'h0, relay}, 32'h7f);
    ticks(20);
    bus(1'b1, rbw_pkg::CTRL_OFS, {25'h0, c});
    check({25'h0, relay}, 32'h7f);
    for (i = 0; i < 30 && relay !== 7'h40; i++) @(posedge ref_clk);
    check({25'h0, relay}, 32'h40);
    check({25'h0, led}, {31'h0, bt});
    check({31'h0, irq}, 32'h1);
    rd(rbw_pkg::STATUS_OFS, 32'h140);
    rd(rbw_pkg::TIMER_OFS, 32'h31);
  endtask
  task automatic t_recover();
    cmd(7'h7e);
    check({25'h0, relay}, 32'h7f);
    rd(rbw_pkg::IRQ_STAT_OFS, 32'h7);
    bus(1'b1, rbw_pkg::IRQ_CLR_OFS, 32'h7);
    rd(rbw_pkg::IRQ_STAT_OFS, 32'h0);
    check({31'h0, irq}, 32'h0);
  endtask
  // ce low for longer than the limit: the stuck timer must not advance
  task automatic t_freeze();
    @(posedge ref_clk);
    ce <= 1'b0;
    ticks(60);
    ce <= 1'b1;
    ticks(2);
    check({25'h0, relay}, 32'h7f);
    rd(rbw_pkg::IRQ_STAT_OFS, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    ticks(4);
    srst <= 1'b0;
    ticks(1);
    t_reset();
    t_cmds();
    t_unmapped();
    t_trip();
    t_recover();
    t_freeze();
    tally_and_finish();
  end
endmodule
`default_nettype wire
